// ---- logic/fps_cpu_end.sv ----
// Processor end: an AXI4-Lite register slave that turns software orders
// into the timed control-write plus store sequence on the link.
// Assumes the flash end shares aclk and aresetn.
`timescale 1ns/1ps
`default_nettype none
module fps_cpu_end
  import fps_pkg::*;
#(
  parameter int AXI_ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  fps_if.cpu link
);
  // ******************************************************************
  // State
  // ******************************************************************
  typedef enum logic [1:0] {
    FPS_SEQ_IDLE = 2'b00,
    FPS_SEQ_CTRL = 2'b01,
    FPS_SEQ_SPM = 2'b10
  } fps_seq_type;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] zptr;
    logic [31:0] data;
    logic [31:0] raddr;
    logic [15:0] rdbuf;
    logic [FPS_INT_W-1:0] istat;
    logic [31:0] imask;
    logic irq;
    fps_seq_type seq;
    logic ctrl_wr;
    logic [FPS_CTRL_W-1:0] ctrl_val;
    logic spm;
    logic rd;
    logic en_prev;
  } fps_cpu_state_type;

  fps_cpu_state_type s_q;
  fps_cpu_state_type s_d;
  logic [FPS_INT_W-1:0] ev;
  logic [FPS_INT_W-1:0] clr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    s_d.ctrl_wr = 1'b0;
    s_d.spm = 1'b0;
    s_d.rd = 1'b0;
    s_d.en_prev = link.ctrl_state[FPS_EN_BIT];
    if (s_q.en_prev && !link.ctrl_state[FPS_EN_BIT]) begin
      ev[FPS_INT_DONE] = 1'b1;
    end
    if (link.rd_valid) begin
      ev[FPS_INT_RD] = 1'b1;
      s_d.rdbuf = link.rd_data;
    end

    // Store follows the control write by one cycle, well inside the window
    case (s_q.seq)
      FPS_SEQ_CTRL: begin
        s_d.spm = 1'b1;
        s_d.seq = FPS_SEQ_SPM;
      end
      FPS_SEQ_SPM: begin
        s_d.seq = FPS_SEQ_IDLE;
      end
      default: begin
        s_d.seq = FPS_SEQ_IDLE;
      end
    endcase

    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = FPS_RESP_OKAY;
      case (s_q.aw_addr)
        FPS_REG_CMD: begin
          // A halted processor cannot issue; a busy sequence cannot restart
          if (s_q.seq == FPS_SEQ_IDLE && !link.halt && s_q.w_strb[0]) begin
            s_d.ctrl_wr = 1'b1;
            s_d.ctrl_val = s_q.w_data[FPS_CTRL_W-1:0];
            s_d.seq = FPS_SEQ_CTRL;
          end else begin
            ev[FPS_INT_REFUSED] = 1'b1;
          end
        end
        FPS_REG_ZPTR: s_d.zptr = merge(s_q.zptr, s_q.w_data, s_q.w_strb) & 32'h0000_FFFF;
        FPS_REG_DATA: s_d.data = merge(s_q.data, s_q.w_data, s_q.w_strb) & 32'h0000_FFFF;
        FPS_REG_RADDR: begin
          s_d.raddr = merge(s_q.raddr, s_q.w_data, s_q.w_strb) & 32'h0000_0FFF;
          s_d.rd = 1'b1;
        end
        FPS_REG_ISTAT: clr = s_q.w_strb[0] ? s_q.w_data[FPS_INT_W-1:0] : '0;
        FPS_REG_IMASK: s_d.imask = merge(s_q.imask, s_q.w_data, s_q.w_strb) & 32'h0000_0007;
        FPS_REG_STATUS, FPS_REG_RDATA: s_d.bresp = FPS_RESP_OKAY;
        default: s_d.bresp = FPS_RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_held;
    s_d.wready = !s_d.w_held;

    if (s_axi_rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = FPS_RESP_OKAY;
      case (8'(s_axi_araddr))
        FPS_REG_CMD: s_d.rdata = {27'h000_0000, s_q.ctrl_val};
        FPS_REG_ZPTR: s_d.rdata = s_q.zptr;
        FPS_REG_DATA: s_d.rdata = s_q.data;
        FPS_REG_STATUS: s_d.rdata = {22'h00_0000, s_q.seq != FPS_SEQ_IDLE, link.halt,
                                     link.ctrl_state};
        FPS_REG_RADDR: s_d.rdata = s_q.raddr;
        FPS_REG_RDATA: s_d.rdata = {16'h0000, s_q.rdbuf};
        FPS_REG_ISTAT: s_d.rdata = {29'h0000_0000, s_q.istat};
        FPS_REG_IMASK: s_d.rdata = s_q.imask;
        default: begin
          s_d.rdata = FPS_REG_RESET;
          s_d.rresp = FPS_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // A new event in the clearing cycle stays set
    s_d.istat = (s_q.istat & ~clr) | ev;
    s_d.irq = |(s_d.istat & s_d.imask[FPS_INT_W-1:0]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign irq = s_q.irq;
  assign link.ctrl_wr = s_q.ctrl_wr;
  assign link.ctrl_val = s_q.ctrl_val;
  assign link.spm = s_q.spm;
  assign link.z_ptr = s_q.zptr[15:0];
  assign link.spm_data = s_q.data[15:0];
  assign link.rd = s_q.rd;
  assign link.rd_addr = s_q.raddr[FPS_ADDR_W-1:0];

endmodule
`default_nettype wire

// ---- logic/fps_flash_end.sv ----
// Flash end: control register, temporary page buffer, flash array and
// the timed page erase / page write sequencer.
// Assumes the processor end drives the link on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fps_flash_end
  import fps_pkg::*;
#(
  parameter int PROG_CYCLES = FPS_PROG_CYCLES,
  parameter int HALT_FIRST_PAGE = FPS_HALT_FIRST_PAGE
) (
  input wire logic aclk,
  input wire logic aresetn,
  fps_if.flash link,
  output logic op_busy
);
  localparam int PAGE_WORDS = 1 << FPS_WORD_W;

  // ******************************************************************
  // State
  // ******************************************************************
  typedef enum logic [1:0] {
    FPS_OP_IDLE = 2'b00,
    FPS_OP_ERASE = 2'b01,
    FPS_OP_WRITE = 2'b10
  } fps_op_type;

  typedef struct packed {
    logic [FPS_CTRL_W-1:0] ctrl;
    logic [2:0] win;
    logic section_busy_flag;
    fps_op_type op;
    logic halt;
    logic [FPS_PAGE_W-1:0] page;
    logic [31:0] timer;
    logic [PAGE_WORDS-1:0] filled;
    logic rd_valid;
    logic [FPS_DATA_W-1:0] rd_data;
  } fps_flash_state_type;

  fps_flash_state_type s_q;
  fps_flash_state_type s_d;

  // Flash content is not reset: it survives a system reset like real flash
  logic [FPS_DATA_W-1:0] flash_mem [1 << FPS_ADDR_W];
  logic [FPS_DATA_W-1:0] page_buf [PAGE_WORDS];
  logic load_en;
  logic erase_en;
  logic write_en;
  logic [FPS_WORD_W-1:0] z_word;
  logic [FPS_PAGE_W-1:0] z_page;
  logic [FPS_PAGE_W-1:0] rd_page;

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic in_read_while_write(input logic [FPS_PAGE_W-1:0] page);
    return page < FPS_PAGE_W'(HALT_FIRST_PAGE);
  endfunction

  function automatic logic legal_ctrl(input logic [FPS_CTRL_W-1:0] v);
    // Lock-bit setting is accepted into the register but has no action here
    return (v == FPS_CMD_LOAD) || (v == FPS_CMD_ERASE) || (v == FPS_CMD_WRITE) ||
           (v == FPS_CMD_LOCK) || (v == FPS_CMD_RRE);
  endfunction

  // Pointer bit 0 selects a byte and is ignored for stores
  assign z_word = link.z_ptr[FPS_WORD_W:1];
  assign z_page = link.z_ptr[FPS_ADDR_W:FPS_WORD_W+1];
  assign rd_page = link.rd_addr[FPS_ADDR_W-1:FPS_WORD_W];

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    s_d = s_q;
    load_en = 1'b0;
    erase_en = 1'b0;
    write_en = 1'b0;
    s_d.rd_valid = 1'b0;

    // Four-cycle window after a control write
    if (s_q.ctrl[FPS_EN_BIT] && s_q.op == FPS_OP_IDLE) begin
      if (s_q.win == 3'(FPS_SPM_WINDOW - 1)) begin
        s_d.ctrl = '0;
        s_d.win = '0;
      end else begin
        s_d.win = s_q.win + 3'd1;
      end
    end

    // Writes while an operation runs have no effect; so do illegal patterns
    if (link.ctrl_wr && s_q.op == FPS_OP_IDLE && legal_ctrl(link.ctrl_val)) begin
      s_d.ctrl = link.ctrl_val;
      s_d.win = '0;
    end else if (link.spm && s_q.ctrl[FPS_EN_BIT] && s_q.op == FPS_OP_IDLE) begin
      s_d.ctrl = '0;
      s_d.win = '0;
      case (s_q.ctrl)
        FPS_CMD_LOAD: begin
          // Any word order, no erase interlock, so the buffer survives erase
          load_en = 1'b1;
          s_d.filled[z_word] = 1'b1;
          s_d.section_busy_flag = 1'b0;
        end
        FPS_CMD_ERASE, FPS_CMD_WRITE: begin
          // Enable stays high until the operation completes
          s_d.ctrl = s_q.ctrl;
          s_d.op = (s_q.ctrl == FPS_CMD_ERASE) ? FPS_OP_ERASE : FPS_OP_WRITE;
          s_d.page = z_page;
          s_d.timer = '0;
          if (in_read_while_write(z_page)) begin
            s_d.section_busy_flag = 1'b1;
          end else begin
            s_d.halt = 1'b1;
          end
        end
        FPS_CMD_RRE: begin
          // Also aborts a fill in progress: loaded words are lost
          s_d.section_busy_flag = 1'b0;
          s_d.filled = '0;
        end
        default: begin
          s_d.ctrl = '0;
        end
      endcase
    end

    // Running operation
    if (s_q.op != FPS_OP_IDLE) begin
      if (s_q.timer == 32'(PROG_CYCLES - 1)) begin
        s_d.op = FPS_OP_IDLE;
        s_d.halt = 1'b0;
        s_d.ctrl = '0;
        if (s_q.op == FPS_OP_WRITE) begin
          write_en = 1'b1;
          s_d.filled = '0;
        end else begin
          erase_en = 1'b1;
        end
      end else begin
        s_d.timer = s_q.timer + 32'd1;
      end
    end

    // Reads: old data until the erase lands, blocked section reads erased
    if (link.rd) begin
      s_d.rd_valid = 1'b1;
      if (s_q.section_busy_flag && in_read_while_write(rd_page)) begin
        s_d.rd_data = FPS_ERASED;
      end else begin
        s_d.rd_data = flash_mem[link.rd_addr];
      end
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Unfilled buffer words program as erased, overwriting those cells with FPS_ERASED
  always_ff @(posedge aclk) begin
    if (load_en) begin
      page_buf[z_word] <= link.spm_data;
    end
    for (int i = 0; i < PAGE_WORDS; i++) begin
      if (erase_en) begin
        flash_mem[{s_q.page, FPS_WORD_W'(i)}] <= FPS_ERASED;
      end else if (write_en) begin
        flash_mem[{s_q.page, FPS_WORD_W'(i)}] <= s_q.filled[i] ? page_buf[i] : FPS_ERASED;
      end
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign link.ctrl_state = {1'b0, s_q.section_busy_flag, 1'b0, s_q.ctrl};
  assign link.halt = s_q.halt;
  assign link.rd_valid = s_q.rd_valid;
  assign link.rd_data = s_q.rd_data;
  assign op_busy = (s_q.op != FPS_OP_IDLE);

endmodule
`default_nettype wire

// ---- logic/fps_if.sv ----
// Link between the processor end and the flash end.
// Both ends run on the same clock; the bench ties them to one aclk.
`timescale 1ns/1ps
`default_nettype none
interface fps_if;
  import fps_pkg::*;
  logic ctrl_wr;
  logic [FPS_CTRL_W-1:0] ctrl_val;
  logic spm;
  logic [15:0] z_ptr;
  logic [FPS_DATA_W-1:0] spm_data;
  logic rd;
  logic [FPS_ADDR_W-1:0] rd_addr;
  logic [7:0] ctrl_state;
  logic halt;
  logic rd_valid;
  logic [FPS_DATA_W-1:0] rd_data;
  modport cpu (
    output ctrl_wr,
    output ctrl_val,
    output spm,
    output z_ptr,
    output spm_data,
    output rd,
    output rd_addr,
    input ctrl_state,
    input halt,
    input rd_valid,
    input rd_data
  );
  modport flash (
    input ctrl_wr,
    input ctrl_val,
    input spm,
    input z_ptr,
    input spm_data,
    input rd,
    input rd_addr,
    output ctrl_state,
    output halt,
    output rd_valid,
    output rd_data
  );
endinterface
`default_nettype wire

// ---- logic/fps_pkg.sv ----
// Constants shared by both ends of the flash page self-programming link.
// Assumes a single 50 MHz clock shared by the processor end and the flash end.
`default_nettype none
package fps_pkg;
  // ******************************************************************
  // Flash geometry
  // ******************************************************************
  localparam int FPS_DATA_W = 16;
  localparam int FPS_ADDR_W = 12;
  localparam int FPS_WORD_W = 5;
  localparam int FPS_PAGE_W = FPS_ADDR_W - FPS_WORD_W;
  localparam int FPS_HALT_FIRST_PAGE = 96;
  localparam logic [15:0] FPS_ERASED = 16'hFFFF;
  // ******************************************************************
  // Control register layout and accepted commands
  // ******************************************************************
  localparam int FPS_CTRL_W = 5;
  localparam int FPS_EN_BIT = 0;
  localparam int FPS_BUSY_BIT = 6;
  localparam logic [4:0] FPS_CMD_LOAD = 5'h01;
  localparam logic [4:0] FPS_CMD_ERASE = 5'h03;
  localparam logic [4:0] FPS_CMD_WRITE = 5'h05;
  localparam logic [4:0] FPS_CMD_LOCK = 5'h09;
  localparam logic [4:0] FPS_CMD_RRE = 5'h11;
  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int FPS_SPM_WINDOW = 4;
  localparam int FPS_CLK_MHZ = 50;
  localparam int FPS_PROG_TIME_US = 3700;
  localparam int FPS_PROG_CYCLES = FPS_PROG_TIME_US * FPS_CLK_MHZ;
  // ******************************************************************
  // Processor-end register map (AXI4-Lite byte offsets)
  // ******************************************************************
  localparam logic [7:0] FPS_REG_CMD = 8'h00;
  localparam logic [7:0] FPS_REG_ZPTR = 8'h04;
  localparam logic [7:0] FPS_REG_DATA = 8'h08;
  localparam logic [7:0] FPS_REG_STATUS = 8'h0C;
  localparam logic [7:0] FPS_REG_RADDR = 8'h10;
  localparam logic [7:0] FPS_REG_RDATA = 8'h14;
  localparam logic [7:0] FPS_REG_ISTAT = 8'h18;
  localparam logic [7:0] FPS_REG_IMASK = 8'h1C;
  localparam logic [1:0] FPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPS_RESP_SLVERR = 2'h2;
  localparam int FPS_INT_W = 3;
  localparam int FPS_INT_DONE = 0;
  localparam int FPS_INT_RD = 1;
  localparam int FPS_INT_REFUSED = 2;
  localparam logic [31:0] FPS_REG_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- verif/flash_page_self_programming_tb_top.sv ----
// Testbench: drives the processor end over AXI4-Lite, both ends joined.
// Assumes one 50 MHz clock and a shortened programming time.
`timescale 1ns/1ps
`default_nettype none
module flash_page_self_programming_tb_top
  import fps_pkg::*;
;
  // Short erase/write keeps the run brief; the checker gets the same
  localparam int PROG = 40;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, op_busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic irq_exp = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 aclk = ~aclk;
  fps_if link ();
  fps_cpu_end i_fps_cpu_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link));
  fps_flash_end #(.PROG_CYCLES(PROG), .HALT_FIRST_PAGE(96)) i_fps_flash_end (.aclk(aclk),
    .aresetn(aresetn), .link(link), .op_busy(op_busy));
  fps_link_asserts #(.PROG_CYCLES(PROG), .HALT_FIRST_PAGE(96)) i_fps_link_asserts (
    .aclk(aclk), .aresetn(aresetn), .ctrl_wr(link.ctrl_wr), .ctrl_val(link.ctrl_val),
    .spm(link.spm), .z_ptr(link.z_ptr), .rd(link.rd), .rd_addr(link.rd_addr),
    .ctrl_state(link.ctrl_state), .halt(link.halt), .rd_valid(link.rd_valid),
    .rd_data(link.rd_data));
  // ******************************************************************
  // Bus tasks and comparison
  // ******************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t;
    logic w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    check({30'b0, bresp}, {30'b0, er});
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(a, v, r);
    check(v, exp);
    check({30'b0, r}, {30'b0, er});
  endtask
  task automatic wait_done();
    logic [31:0] v;
    logic [1:0] r;
    v = '0;
    while (!v[FPS_INT_DONE]) axi_rd(FPS_REG_ISTAT, v, r);
    check({31'b0, irq}, {31'b0, irq_exp});
    axi_wr(FPS_REG_ISTAT, 32'h0000_0001, FPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'b0, irq}, 32'h0000_0000);
  endtask
  task automatic op(input logic [6:0] pg, input logic [4:0] c);
    axi_wr(FPS_REG_ZPTR, {19'b0, pg, 5'b0, 1'b0}, FPS_RESP_OKAY);
    axi_wr(FPS_REG_CMD, {27'b0, c}, FPS_RESP_OKAY);
    wait_done();
  endtask
  // Pointer bit 0 is set on purpose: the word store must ignore it
  task automatic ld(input logic [6:0] pg, input logic [4:0] wd, input logic [15:0] d);
    axi_wr(FPS_REG_ZPTR, {19'b0, pg, wd, 1'b1}, FPS_RESP_OKAY);
    axi_wr(FPS_REG_DATA, {16'b0, d}, FPS_RESP_OKAY);
    axi_wr(FPS_REG_CMD, {27'b0, FPS_CMD_LOAD}, FPS_RESP_OKAY);
    wait_done();
  endtask
  task automatic fchk(input logic [6:0] pg, input logic [4:0] wd, input logic [15:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    v = '0;
    axi_wr(FPS_REG_RADDR, {20'b0, pg, wd}, FPS_RESP_OKAY);
    while (!v[FPS_INT_RD]) axi_rd(FPS_REG_ISTAT, v, r);
    axi_wr(FPS_REG_ISTAT, 32'h0000_0002, FPS_RESP_OKAY);
    rchk(FPS_REG_RDATA, {16'b0, exp}, FPS_RESP_OKAY);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(FPS_REG_STATUS, 32'h0000_0000, FPS_RESP_OKAY);
    rchk(8'h20, 32'h0000_0000, FPS_RESP_SLVERR);
    axi_wr(8'h24, 32'h0000_0001, FPS_RESP_SLVERR);
    // Erase first, interrupt masked, then fill out of order
    op(7'd3, FPS_CMD_ERASE);
    rchk(FPS_REG_STATUS, 32'h0000_0040, FPS_RESP_OKAY);
    fchk(7'd3, 5'd0, FPS_ERASED);
    axi_wr(FPS_REG_IMASK, 32'h0000_0001, FPS_RESP_OKAY);
    irq_exp = 1'b1;
    ld(7'd3, 5'd31, 16'hA55A);
    rchk(FPS_REG_STATUS, 32'h0000_0000, FPS_RESP_OKAY);
    ld(7'd3, 5'd0, 16'h1234);
    ld(7'd3, 5'd7, 16'h0F0F);
    op(7'd3, FPS_CMD_WRITE);
    op(7'd3, FPS_CMD_RRE);
    fchk(7'd3, 5'd31, 16'hA55A);
    fchk(7'd3, 5'd0, 16'h1234);
    fchk(7'd3, 5'd7, 16'h0F0F);
    fchk(7'd3, 5'd1, FPS_ERASED);
    // Fill before erase: old data still readable, kept word survives
    ld(7'd3, 5'd1, 16'h5AA5);
    fchk(7'd3, 5'd31, 16'hA55A);
    ld(7'd3, 5'd31, 16'hA55A);
    op(7'd3, FPS_CMD_ERASE);
    fchk(7'd3, 5'd0, FPS_ERASED);
    op(7'd3, FPS_CMD_WRITE);
    op(7'd3, FPS_CMD_RRE);
    fchk(7'd3, 5'd1, 16'h5AA5);
    fchk(7'd3, 5'd31, 16'hA55A);
    fchk(7'd3, 5'd0, FPS_ERASED);
    // Buffer emptied by re-enable: loaded word 2 not written to page 4
    op(7'd4, FPS_CMD_ERASE);
    op(7'd4, FPS_CMD_WRITE);
    ld(7'd4, 5'd2, 16'hBEEF);
    op(7'd4, FPS_CMD_RRE);
    op(7'd4, FPS_CMD_WRITE);
    op(7'd4, FPS_CMD_RRE);
    fchk(7'd4, 5'd1, FPS_ERASED);
    fchk(7'd4, 5'd2, FPS_ERASED);
    fchk(7'd3, 5'd1, 16'h5AA5);
    // Page in the halting section, with a refused order mid-operation
    ld(7'd100, 5'd2, 16'hC3C3);
    axi_wr(FPS_REG_ZPTR, {19'b0, 7'd100, 6'b0}, FPS_RESP_OKAY);
    axi_wr(FPS_REG_CMD, {27'b0, FPS_CMD_ERASE}, FPS_RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({31'b0, op_busy}, 32'h0000_0001);
    rchk(FPS_REG_STATUS, 32'h0000_0103, FPS_RESP_OKAY);
    axi_wr(FPS_REG_CMD, {27'b0, FPS_CMD_LOAD}, FPS_RESP_OKAY);
    rchk(FPS_REG_ISTAT, 32'h0000_0004, FPS_RESP_OKAY);
    axi_wr(FPS_REG_ISTAT, 32'h0000_0004, FPS_RESP_OKAY);
    wait_done();
    op(7'd100, FPS_CMD_WRITE);
    fchk(7'd100, 5'd2, 16'hC3C3);
    fchk(7'd100, 5'd3, FPS_ERASED);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verif/fps_link_asserts.sv ----
// Checker for the link between the processor end and the flash end.
// Assumes it sits beside the link interface, on the one shared clock.
`timescale 1ns/1ps
`default_nettype none
module fps_link_asserts
  import fps_pkg::*;
#(
  parameter int PROG_CYCLES = FPS_PROG_CYCLES,
  parameter int HALT_FIRST_PAGE = FPS_HALT_FIRST_PAGE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ctrl_wr,
  input wire logic [FPS_CTRL_W-1:0] ctrl_val,
  input wire logic spm,
  input wire logic [15:0] z_ptr,
  input wire logic rd,
  input wire logic [FPS_ADDR_W-1:0] rd_addr,
  input wire logic [7:0] ctrl_state,
  input wire logic halt,
  input wire logic rd_valid,
  input wire logic [FPS_DATA_W-1:0] rd_data
);
  // ******************************************************************
  // Length of the running erase or write, counted on the command bits
  // ******************************************************************
  logic [31:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= '0;
    end else if (|ctrl_state[2:1]) begin
      run_q <= run_q + 32'd1;
    end else begin
      run_q <= '0;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_load_clears_en;
    spm && ctrl_state[4:0] == FPS_CMD_LOAD |=> !ctrl_state[FPS_EN_BIT] && !ctrl_state[FPS_BUSY_BIT];
  endproperty
  a_load_clears_en: assert property (p_load_clears_en) else $error("load left enable set");
  property p_erase_latch;
    ctrl_wr && ctrl_val == FPS_CMD_ERASE && !ctrl_state[FPS_EN_BIT] |=>
      ctrl_state[4:0] == FPS_CMD_ERASE;
  endproperty
  a_erase_latch: assert property (p_erase_latch) else $error("erase order not latched");
  property p_open_busy;
    spm && ctrl_state[FPS_EN_BIT] && |ctrl_state[2:1] && z_ptr[12:6] < HALT_FIRST_PAGE |=>
      ctrl_state[FPS_BUSY_BIT] && !halt;
  endproperty
  a_open_busy: assert property (p_open_busy) else $error("section busy not set");
  property p_protected_halt;
    spm && ctrl_state[FPS_EN_BIT] && |ctrl_state[2:1] && z_ptr[12:6] >= HALT_FIRST_PAGE |=> halt;
  endproperty
  a_protected_halt: assert property (p_protected_halt) else $error("processor not halted");
  property p_run_length;
    $fell(|ctrl_state[2:1]) |-> run_q >= PROG_CYCLES - 1 && run_q <= PROG_CYCLES + 3;
  endproperty
  a_run_length: assert property (p_run_length) else $error("operation length wrong");
  property p_halt_ends;
    $fell(|ctrl_state[2:1]) |-> ##[0:1] !halt;
  endproperty
  a_halt_ends: assert property (p_halt_ends) else $error("halt outlived operation");
  property p_rre_clears;
    spm && ctrl_state[4:0] == FPS_CMD_RRE |=> !ctrl_state[FPS_BUSY_BIT] && !ctrl_state[FPS_EN_BIT];
  endproperty
  a_rre_clears: assert property (p_rre_clears) else $error("re-enable left busy set");
  property p_read_answer;
    rd |=> rd_valid ##1 !rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer not one pulse");
  property p_busy_blocks;
    rd && ctrl_state[FPS_BUSY_BIT] && rd_addr[11:5] < HALT_FIRST_PAGE |=> rd_data == FPS_ERASED;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("busy section was readable");
endmodule
`default_nettype wire
